/* rtl/ldp_dimming_top.sv */
// Dimming controller: two-wire register port, external duty monitor and phased PWM.
`timescale 1ns/1ps
// How it works
// - After reset the block runs product dimming of internal code and external duty.
// - Current code register takes 0 to 255, resets to 255, sets linear current.
// - Current code left at reset value drives full resistor-set current.
// - Current code zero turns all six channels off.
// - Current code changes take effect at once while running.
// - Internal mode duty is duty code over 255, giving 256 steps.
// - Duty code resets to 255; duty code zero turns all channels off except in external mode.
// - Product mode runs at internal rate with duty external times code over 255.
// - External input low longer than 28 ms puts the block in shutdown.
// - Internal dimming rate comes from the resistor-set oscillator.
// - Chopping applies to all six channels at the programmed current.
// - After reset staggering is off and all channels switch together.
// - Even-spread bit set spreads turn-on times over the period by channel count.
// - Even gap is floor(255/N) steps; the last gap takes the remainder.
// - The block counts its operating channels itself.
module ldp_dimming_top #(
    parameter longint OFF_LIMIT_CYCLES = ldp_pkg::OFF_LIMIT_CYC
) (
    // Core clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Oscillator clock set by the dimming rate resistor
    input  wire logic       dimming_rate_clk,
    // Two-wire register port
    input  wire logic       bus_clock_pin,
    input  wire logic       bus_data_in,
    output logic            bus_data_out,
    output logic            bus_data_oe,
    // External duty input and channel sensing
    input  wire logic       external_duty,
    input  wire logic [5:0] chan_present,
    // Channel drive
    output logic [5:0]      led_on,
    output logic [7:0]      dc_current_code,
    output logic            shutdown
);

    typedef struct packed {
        logic                       scl_s1, scl_s2, scl_s3;
        logic                       sda_s1, sda_s2, sda_s3;
        logic                       ext_s1, ext_s2, ext_s3;
        ldp_pkg::ldp_bus_st_t       st;
        logic [3:0]                 bitc;
        logic [7:0]                 shreg;
        logic                       rw;
        logic [7:0]                 ptr;
        logic                       sda_oe;
        logic [7:0]                 duty;
        logic [7:0]                 mode;
        logic [7:0]                 dc;
        logic [7:0]                 phase;
        logic [ldp_pkg::CNT_W-1:0]  hi_cnt, per_cnt, low_cnt;
        logic                       shut;
        logic [ldp_pkg::CNT_W:0]    div_rem;
        logic [ldp_pkg::CNT_W-1:0]  div_den;
        logic [8:0]                 div_q;
        logic [3:0]                 div_n;
        logic                       div_busy;
        logic [7:0]                 ext8;
        ldp_pkg::ldp_cfg_t          xfer;
        logic                       req, ack_s1, ack_s2;
    } ldp_core_t;

    typedef struct packed {
        logic               req_s1, req_s2, seen;
        ldp_pkg::ldp_cfg_t  act, pend;
        logic               pend_v;
        logic               off;
        logic [5:0]         chan_s1, chan_s2;
        logic               ext_s1, ext_s2;
        logic [7:0]         cnt;
        logic [5:0]         led;
    } ldp_dim_t;

    localparam logic [ldp_pkg::CNT_W-1:0] OFF_LIM = ldp_pkg::CNT_W'(OFF_LIMIT_CYCLES);

    function automatic ldp_pkg::ldp_mode_t mode_of(input logic [7:0] code);
        if (code == ldp_pkg::MODE_CODE_INT) begin
            return ldp_pkg::LDP_INTERNAL;
        end else if (code == ldp_pkg::MODE_CODE_EXT) begin
            return ldp_pkg::LDP_EXTERNAL;
        end
        return ldp_pkg::LDP_PRODUCT;
    endfunction

    function automatic logic [7:0] read_of(input ldp_core_t s, input logic [7:0] p);
        case (p)
            ldp_pkg::REG_DUTY:  return s.duty;
            ldp_pkg::REG_MODE:  return s.mode;
            ldp_pkg::REG_DC:    return s.dc;
            ldp_pkg::REG_PHASE: return s.phase;
            default:            return 8'h00;
        endcase
    endfunction

    function automatic logic [2:0] count_of(input logic [5:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < ldp_pkg::NCH; i++) begin
            n = n + {2'h0, v[i]};
        end
        return n;
    endfunction

    function automatic logic [7:0] even_gap(input logic [2:0] n);
        case (n)
            3'h1:    return 8'hFF;
            3'h2:    return 8'h7F;
            3'h3:    return 8'h55;
            3'h4:    return 8'h3F;
            3'h5:    return 8'h33;
            3'h6:    return 8'h2A;
            default: return 8'h00;
        endcase
    endfunction

    // ---------------- Core clock domain ----------------
    ldp_core_t c_q, c_d;
    ldp_dim_t  d_q, d_d;
    logic        wr_en;
    logic [15:0] prod;

    always_comb begin
        logic scl_r, scl_f, start, stop, rise;
        logic [ldp_pkg::CNT_W:0] rem2;
        ldp_pkg::ldp_cfg_t now;
        c_d   = c_q;
        wr_en = 1'b0;
        rem2  = '0;
        c_d.scl_s1 = bus_clock_pin;
        c_d.scl_s2 = c_q.scl_s1;
        c_d.scl_s3 = c_q.scl_s2;
        c_d.sda_s1 = bus_data_in;
        c_d.sda_s2 = c_q.sda_s1;
        c_d.sda_s3 = c_q.sda_s2;
        c_d.ext_s1 = external_duty;
        c_d.ext_s2 = c_q.ext_s1;
        c_d.ext_s3 = c_q.ext_s2;
        c_d.ack_s1 = d_q.seen;
        c_d.ack_s2 = c_q.ack_s1;
        scl_r = c_q.scl_s2 & ~c_q.scl_s3;
        scl_f = ~c_q.scl_s2 & c_q.scl_s3;
        start = c_q.scl_s2 & c_q.scl_s3 & c_q.sda_s3 & ~c_q.sda_s2;
        stop  = c_q.scl_s2 & c_q.scl_s3 & ~c_q.sda_s3 & c_q.sda_s2;
        rise  = c_q.ext_s2 & ~c_q.ext_s3;
        // Register port; the ack and data bits change only on clock falls.
        case (c_q.st)
            ldp_pkg::LDP_ADDR, ldp_pkg::LDP_PTR, ldp_pkg::LDP_WDAT: begin
                if (scl_r) begin
                    c_d.shreg = {c_q.shreg[6:0], c_q.sda_s2};
                    c_d.bitc  = c_q.bitc + 4'h1;
                end else if (scl_f && c_q.bitc == 4'h8) begin
                    c_d.bitc   = 4'h0;
                    c_d.sda_oe = 1'b1;
                    if (c_q.st == ldp_pkg::LDP_ADDR) begin
                        c_d.rw = c_q.shreg[0];
                        c_d.st = ldp_pkg::LDP_AACK;
                        if (c_q.shreg[7:1] != ldp_pkg::BUS_ADDR) begin
                            c_d.sda_oe = 1'b0;
                            c_d.st     = ldp_pkg::LDP_IDLE;
                        end
                    end else if (c_q.st == ldp_pkg::LDP_PTR) begin
                        c_d.ptr = c_q.shreg;
                        c_d.st  = ldp_pkg::LDP_PACK;
                    end else begin
                        wr_en   = 1'b1;
                        c_d.ptr = c_q.ptr + 8'h01;
                        c_d.st  = ldp_pkg::LDP_WACK;
                    end
                end
            end
            ldp_pkg::LDP_AACK, ldp_pkg::LDP_PACK, ldp_pkg::LDP_WACK: begin
                if (scl_f) begin
                    c_d.sda_oe = 1'b0;
                    if (c_q.st == ldp_pkg::LDP_AACK && c_q.rw) begin
                        c_d.shreg  = read_of(c_q, c_q.ptr);
                        c_d.sda_oe = ~c_d.shreg[7];
                        c_d.st     = ldp_pkg::LDP_RDAT;
                    end else begin
                        c_d.st = (c_q.st == ldp_pkg::LDP_AACK) ? ldp_pkg::LDP_PTR
                                                               : ldp_pkg::LDP_WDAT;
                    end
                end
            end
            ldp_pkg::LDP_RDAT: begin
                if (scl_r) begin
                    c_d.bitc = c_q.bitc + 4'h1;
                end else if (scl_f && c_q.bitc == 4'h8) begin
                    c_d.bitc   = 4'h0;
                    c_d.sda_oe = 1'b0;
                    c_d.ptr    = c_q.ptr + 8'h01;
                    c_d.st     = ldp_pkg::LDP_RACK;
                end else if (scl_f) begin
                    c_d.shreg  = {c_q.shreg[6:0], 1'b0};
                    c_d.sda_oe = ~c_q.shreg[6];
                end
            end
            ldp_pkg::LDP_RACK: begin
                if (scl_r && c_q.sda_s2) begin
                    c_d.st = ldp_pkg::LDP_IDLE;
                end else if (scl_f) begin
                    c_d.shreg  = read_of(c_q, c_q.ptr);
                    c_d.sda_oe = ~c_d.shreg[7];
                    c_d.st     = ldp_pkg::LDP_RDAT;
                end
            end
            default: begin
                c_d.st = ldp_pkg::LDP_IDLE;
            end
        endcase
        if (start) begin
            c_d.st     = ldp_pkg::LDP_ADDR;
            c_d.bitc   = 4'h0;
            c_d.sda_oe = 1'b0;
        end else if (stop) begin
            c_d.st     = ldp_pkg::LDP_IDLE;
            c_d.sda_oe = 1'b0;
        end
        if (wr_en) begin
            case (c_q.ptr)
                ldp_pkg::REG_DUTY:  c_d.duty  = c_q.shreg;
                ldp_pkg::REG_MODE:  c_d.mode  = c_q.shreg;
                ldp_pkg::REG_DC:    c_d.dc    = c_q.shreg;
                ldp_pkg::REG_PHASE: c_d.phase = c_q.shreg;
                default:            c_d.ptr   = c_q.ptr + 8'h01;
            endcase
        end
        // External duty monitor: high and period counts feed a serial divider.
        c_d.per_cnt = (c_q.per_cnt == ldp_pkg::CNT_MAX) ? c_q.per_cnt : c_q.per_cnt + 1'b1;
        if (c_q.ext_s2) begin
            c_d.low_cnt = '0;
            c_d.hi_cnt  = (c_q.hi_cnt == ldp_pkg::CNT_MAX) ? c_q.hi_cnt : c_q.hi_cnt + 1'b1;
        end else if (c_q.low_cnt != ldp_pkg::CNT_MAX) begin
            c_d.low_cnt = c_q.low_cnt + 1'b1;
        end
        if (c_q.div_busy) begin
            rem2 = {c_q.div_rem[ldp_pkg::CNT_W-1:0], 1'b0};
            c_d.div_q = {c_q.div_q[7:0], 1'b0};
            if (rem2 >= {1'b0, c_q.div_den}) begin
                rem2      = rem2 - {1'b0, c_q.div_den};
                c_d.div_q = {c_q.div_q[7:0], 1'b1};
            end
            c_d.div_rem = rem2;
            c_d.div_n   = c_q.div_n - 4'h1;
            if (c_q.div_n == 4'h1) begin
                c_d.div_busy = 1'b0;
                // Nine fraction bits halved give 256 times high over period; full duty gives 255.
                c_d.ext8     = c_d.div_q[8:1];
            end
        end
        if (rise) begin
            c_d.shut    = 1'b0;
            c_d.hi_cnt  = {{(ldp_pkg::CNT_W-1){1'b0}}, 1'b1};
            c_d.per_cnt = {{(ldp_pkg::CNT_W-1){1'b0}}, 1'b1};
            if (!c_q.div_busy) begin
                c_d.div_rem  = {1'b0, c_q.hi_cnt};
                c_d.div_den  = c_q.per_cnt;
                c_d.div_q    = 9'h000;
                c_d.div_n    = 4'h9;
                c_d.div_busy = 1'b1;
            end
        end else if (c_q.ext_s2 && c_q.per_cnt >= OFF_LIM) begin
            c_d.ext8 = 8'hFF;
        end
        // The stale low count must not undo the clear on the rising edge.
        if (!c_q.ext_s2 && c_q.low_cnt >= OFF_LIM) begin
            c_d.shut = 1'b1;
            c_d.ext8 = 8'h00;
        end
        // Product duty: exact floor of code times measured duty over 255.
        prod = c_q.duty * c_q.ext8;
        now.mode = mode_of(c_q.mode);
        now.duty = (now.mode == ldp_pkg::LDP_PRODUCT)
                 ? 8'((17'(prod) + 17'(prod[15:8]) + 17'h0_0001) >> 8) : c_q.duty;
        now.even = c_q.phase[ldp_pkg::PH_EVEN_BIT];
        now.step = c_q.phase[6:0];
        now.off  = (c_q.dc == 8'h00) | c_q.shut;
        // A new word is sent only after the previous one is acknowledged.
        if (now != c_q.xfer && c_q.req == c_q.ack_s2) begin
            c_d.xfer = now;
            c_d.req  = ~c_q.req;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            c_q       <= '0;
            c_q.st    <= ldp_pkg::LDP_IDLE;
            c_q.duty  <= ldp_pkg::DUTY_RST;
            c_q.mode  <= ldp_pkg::MODE_RST;
            c_q.dc    <= ldp_pkg::DC_RST;
            c_q.phase <= ldp_pkg::PHASE_RST;
            c_q.xfer  <= ldp_pkg::CFG_RST;
        end else begin
            c_q <= c_d;
        end
    end

    // ---------------- Dimming clock domain ----------------
    // One period is 255 ticks of the resistor oscillator.
    logic [5:0] chan_on;
    logic [2:0] n_ops;
    logic [7:0] gap;
    assign n_ops = count_of(d_q.chan_s2);
    assign gap   = even_gap(n_ops);

    for (genvar k = 0; k < ldp_pkg::NCH; k++) begin : g_ch
        logic [9:0] raw;
        logic [9:0] offs;
        logic [9:0] rel;
        assign raw = d_q.act.even
                   ? 10'(count_of(d_q.chan_s2 & 6'((1 << k) - 1)) * gap)
                   : 10'(k * d_q.act.step);
        assign offs = (raw >= 10'(2 * ldp_pkg::STEP_NUM)) ? raw - 10'(2 * ldp_pkg::STEP_NUM)
                    : (raw >= ldp_pkg::STEP_NUM) ? raw - ldp_pkg::STEP_NUM : raw;
        assign rel = ({2'h0, d_q.cnt} >= offs) ? {2'h0, d_q.cnt} - offs
                   : {2'h0, d_q.cnt} + ldp_pkg::STEP_NUM - offs;
        assign chan_on[k] = rel < {2'h0, d_q.act.duty};
    end

    always_comb begin
        logic wrap;
        d_d = d_q;
        d_d.req_s1  = c_q.req;
        d_d.req_s2  = d_q.req_s1;
        d_d.chan_s1 = chan_present;
        d_d.chan_s2 = d_q.chan_s1;
        d_d.ext_s1  = external_duty;
        d_d.ext_s2  = d_q.ext_s1;
        wrap = (d_q.cnt == ldp_pkg::STEP_LAST);
        d_d.cnt = wrap ? 8'h00 : d_q.cnt + 8'h01;
        if (wrap && d_q.pend_v) begin
            d_d.act    = d_q.pend;
            d_d.pend_v = 1'b0;
        end
        // The word is stable while the toggle is unacknowledged.
        if (d_q.req_s2 != d_q.seen) begin
            d_d.pend   = c_q.xfer;
            d_d.pend_v = 1'b1;
            d_d.off    = c_q.xfer.off;
            d_d.seen   = d_q.req_s2;
        end
        if (d_q.act.mode == ldp_pkg::LDP_EXTERNAL) begin
            d_d.led = {ldp_pkg::NCH{d_q.ext_s2}};
        end else begin
            d_d.led = chan_on;
        end
        if (d_q.off) begin
            d_d.led = 6'h00;
        end
    end

    always_ff @(posedge dimming_rate_clk or negedge arst_n) begin
        if (!arst_n) begin
            d_q      <= '0;
            d_q.act  <= ldp_pkg::CFG_RST;
            d_q.pend <= ldp_pkg::CFG_RST;
        end else begin
            d_q <= d_d;
        end
    end

    assign bus_data_out    = 1'b0 & c_q.sda_oe;
    assign bus_data_oe     = c_q.sda_oe;
    assign dc_current_code = c_q.dc;
    assign shutdown        = c_q.shut;
    assign led_on          = d_q.led;

    // ---------------- Checks ----------------
    sequence s_low_run;
        !c_q.ext_s2 && c_q.low_cnt >= OFF_LIM;
    endsequence

    a_mode_write_only: assert property (@(posedge core_clk) disable iff (!arst_n)
        !$stable(c_q.mode) |-> $past(wr_en && c_q.ptr == ldp_pkg::REG_MODE))
        else $error("mode register changed without a write");
    a_dc_update_now: assert property (@(posedge core_clk) disable iff (!arst_n)
        (wr_en && c_q.ptr == ldp_pkg::REG_DC) |=> dc_current_code == $past(c_q.shreg))
        else $error("current code not applied on the next cycle");
    a_shut_entry: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_low_run |=> shutdown)
        else $error("shutdown missed after long off time");
    a_shut_cause: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(shutdown) |-> $past(c_q.low_cnt) >= OFF_LIM)
        else $error("shutdown without long off time");
    a_period_wrap: assert property (@(posedge dimming_rate_clk) disable iff (!arst_n)
        d_q.cnt == ldp_pkg::STEP_LAST |=> d_q.cnt == 8'h00 ##1 d_q.cnt == 8'h01)
        else $error("period is not 255 ticks");
    a_zero_dark: assert property (@(posedge dimming_rate_clk) disable iff (!arst_n)
        (d_q.act.duty == 8'h00 && d_q.act.mode != ldp_pkg::LDP_EXTERNAL) |=> led_on == 6'h00)
        else $error("channel lit with zero duty");
    a_full_lit: assert property (@(posedge dimming_rate_clk) disable iff (!arst_n)
        (d_q.act.duty == 8'hFF && d_q.act.mode == ldp_pkg::LDP_INTERNAL && !d_q.off)
        |=> led_on == 6'h3F)
        else $error("full duty does not light all channels");
    a_together: assert property (@(posedge dimming_rate_clk) disable iff (!arst_n)
        (!d_q.act.even && d_q.act.step == 7'h00) |=> (&led_on || led_on == 6'h00))
        else $error("channels switch apart with staggering off");
    a_apply_edge: assert property (@(posedge dimming_rate_clk) disable iff (!arst_n)
        !$stable(d_q.act) |-> $past(d_q.cnt) == ldp_pkg::STEP_LAST)
        else $error("settings applied inside a period");

endmodule

/* rtl/ldp_pkg.sv */
// Shared constants, types and register map of the LED dimming and phase block.
package ldp_pkg;

    // Register pointers on the two-wire port.
    localparam logic [7:0] REG_DUTY  = 8'h00;
    localparam logic [7:0] REG_MODE  = 8'h01;
    localparam logic [7:0] REG_DC    = 8'h07;
    localparam logic [7:0] REG_PHASE = 8'h0C;

    // Values after reset.
    localparam logic [7:0] DUTY_RST  = 8'hFF;
    localparam logic [7:0] MODE_RST  = 8'h01;
    localparam logic [7:0] DC_RST    = 8'hFF;
    localparam logic [7:0] PHASE_RST = 8'h00;

    // Mode codes written to the mode register.
    localparam logic [7:0] MODE_CODE_INT = 8'h05;
    localparam logic [7:0] MODE_CODE_EXT = 8'h03;

    // Phase register layout.
    localparam int PH_EVEN_BIT = 7;

    // Dimming period in oscillator ticks, counted 0 to 254.
    localparam logic [7:0] STEP_LAST = 8'hFE;
    localparam logic [9:0] STEP_NUM  = 10'h0FF;
    localparam int         NCH       = 6;

    // Bus address; the value is arbitrary.
    localparam logic [6:0] BUS_ADDR = 7'h2C;

    // Off-time limit of the external duty input.
    localparam longint CORE_CLK_HZ   = 100_000_000;
    localparam longint OFF_LIMIT_MS  = 28;
    localparam longint OFF_LIMIT_CYC = (OFF_LIMIT_MS * CORE_CLK_HZ) / 1000;
    localparam int     CNT_W         = 22;
    localparam logic [CNT_W-1:0] CNT_MAX = 22'h3F_FFFF;

    typedef enum logic [1:0] {
        LDP_PRODUCT  = 2'h0,
        LDP_INTERNAL = 2'h1,
        LDP_EXTERNAL = 2'h2
    } ldp_mode_t;

    typedef enum logic [3:0] {
        LDP_IDLE  = 4'h0,
        LDP_ADDR  = 4'h1,
        LDP_AACK  = 4'h3,
        LDP_PTR   = 4'h2,
        LDP_PACK  = 4'h6,
        LDP_WDAT  = 4'h7,
        LDP_WACK  = 4'h5,
        LDP_RDAT  = 4'h4,
        LDP_RACK  = 4'hC
    } ldp_bus_st_t;

    // Settings word handed to the dimming clock domain.
    typedef struct packed {
        ldp_mode_t  mode;
        logic [7:0] duty;
        logic       even;
        logic [6:0] step;
        logic       off;
    } ldp_cfg_t;

    localparam ldp_cfg_t CFG_RST = '{LDP_PRODUCT, 8'h00, 1'b0, 7'h00, 1'b0};

endpackage

/* bench/ldp_host.sv */
// Partner model: two-wire bus host and external duty source.
`timescale 1ns/1ps
module ldp_host (
    // Clock and bus wire
    input  wire logic core_clk,
    input  wire logic sda,
    // Host drives
    output logic      scl,
    output logic      sda_low,
    output logic      ext
);
    int   ext_hi = 1;
    int   ext_lo = 0;
    int   nacks  = 0;
    logic ack;
    logic [7:0] q;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        ext = 1'b1;
        // A zero low time holds the input high, as enable must be for internal mode.
        forever begin
            ext <= 1'b1;
            repeat (ext_hi) @(posedge core_clk);
            if (ext_lo > 0) ext <= 1'b0;
            repeat (ext_lo) @(posedge core_clk);
        end
    end
    // Data only moves while the clock is low, so no false start or stop is seen.
    task automatic bt(input logic b, output logic s);
        scl <= 1'b0;
        repeat (4) @(posedge core_clk);
        sda_low <= ~b;
        repeat (4) @(posedge core_clk);
        scl <= 1'b1;
        repeat (8) @(posedge core_clk);
        s = sda;
    endtask
    task automatic xb(input logic [7:0] v, output logic [7:0] d, input logic ka);
        for (int i = 7; i >= 0; i--) bt(v[i], d[i]);
        bt(1'b1, ack);
        if (ka && ack !== 1'b0) nacks++;
    endtask
    task automatic st();
        bt(1'b1, ack);
        sda_low <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic sp();
        bt(1'b0, ack);
        sda_low <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    // With no host on the bus both wires are held low.
    task automatic tie();
        scl <= 1'b0;
        repeat (4) @(posedge core_clk);
        sda_low <= 1'b1;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] v);
        st();
        xb({ldp_pkg::BUS_ADDR, 1'b0}, q, 1'b1);
        xb(p, q, 1'b1);
        xb(v, q, 1'b1);
        sp();
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        st();
        xb({ldp_pkg::BUS_ADDR, 1'b0}, q, 1'b1);
        xb(p, q, 1'b1);
        st();
        xb({ldp_pkg::BUS_ADDR, 1'b1}, q, 1'b1);
        xb(8'hFF, d, 1'b0);
        sp();
    endtask
endmodule

/* bench/led_dimming_pwm_phase_tb.sv */
// Self-checking bench of the dimming controller.
`timescale 1ns/1ps
module led_dimming_pwm_phase_tb;
    logic core_clk = 1'b0;
    logic dimming_rate_clk = 1'b0;
    logic arst_n;
    logic [5:0] chan_present;
    logic scl, sda_low, ext, bus_data_oe, bus_data_out, shutdown;
    logic [5:0] led_on;
    logic [7:0] dc_current_code, d, v;
    wire sda = ~sda_low & (bus_data_oe ? bus_data_out : 1'b1);
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 32'h7a1362e5;
    int mdl [int];
    int c, e;
    int ptrs [5] = '{0, 1, 7, 12, 5};
    always #5 core_clk = ~core_clk;
    always #3 dimming_rate_clk = ~dimming_rate_clk;
    ldp_host u_host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low), .ext(ext));
    // The off limit is scaled down but stays above the longest legal external period.
    ldp_dimming_top #(.OFF_LIMIT_CYCLES(4000)) DUT (
        .core_clk(core_clk), .arst_n(arst_n), .dimming_rate_clk(dimming_rate_clk),
        .bus_clock_pin(scl), .bus_data_in(sda), .bus_data_out(bus_data_out),
        .bus_data_oe(bus_data_oe),
        .external_duty(ext), .chan_present(chan_present), .led_on(led_on),
        .dc_current_code(dc_current_code), .shutdown(shutdown));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checked=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Counting over a whole period makes the result independent of where it starts.
    task automatic meas(output int n);
        n = 0;
        repeat (255) begin
            @(posedge dimming_rate_clk);
            n += (led_on[0] === 1'b1);
            if (led_on !== 6'h00 && led_on !== 6'h3F) chk({2'b0, led_on}, 8'h3F);
        end
    endtask
    // Ticks from a turn-on of channel 0 to the next turn-on of channel k.
    task automatic lag(input int k, output int n);
        logic pk;
        int i;
        i = 0;
        pk = 1'b1;
        while (led_on[0] !== 1'b0 && i < 600) begin
            @(posedge dimming_rate_clk);
            i++;
        end
        while (led_on[0] !== 1'b1 && i < 600) begin
            pk = led_on[k];
            @(posedge dimming_rate_clk);
            i++;
        end
        n = 0;
        while ((led_on[k] !== 1'b1 || pk !== 1'b0) && n < 255) begin
            pk = led_on[k];
            @(posedge dimming_rate_clk);
            n++;
        end
    endtask
    task automatic wext(input logic lv);
        int i;
        i = 0;
        while (ext !== lv && i < 20000) begin
            @(posedge core_clk);
            i++;
        end
        if (i == 20000) begin
            chk({7'b0, ext}, {7'b0, lv});
            stop_test();
        end
    endtask
    task automatic wreg(input logic [7:0] p, input logic [7:0] x);
        u_host.wr(p, x);
        if (p == 0 || p == 1 || p == 7 || p == 12) mdl[p] = x;
    endtask
    initial begin
        arst_n = 1'b0;
        chan_present = 6'h3F;
        mdl[0] = 8'hFF; mdl[1] = 8'h01; mdl[7] = 8'hFF; mdl[12] = 0; mdl[5] = 0;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk(dc_current_code, 8'hFF);
        wreg(8'h05, 8'($random(seed)));
        foreach (ptrs[i]) begin
            u_host.rd(8'(ptrs[i]), d);
            chk(d, 8'(mdl[ptrs[i]]));
        end
        $display("register test done");
        v = 8'($random(seed)) | 8'h01;
        wreg(8'h07, v);
        repeat (10) @(posedge core_clk);
        chk(dc_current_code, v);
        wreg(8'h01, ldp_pkg::MODE_CODE_INT);
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 8'h00 : (k == 1) ? (8'($random(seed)) | 8'h01) : 8'hFF;
            wreg(8'h00, v);
            repeat (600) @(posedge dimming_rate_clk);
            meas(c);
            chk(8'(c), v);
        end
        wreg(8'h00, 8'h40);
        v = 8'($random(seed)) & 8'h7F;
        wreg(8'h0C, v);
        repeat (600) @(posedge dimming_rate_clk);
        for (int k = 1; k < 6; k++) begin
            lag(k, c);
            chk(8'(c), 8'((k * v) % 255));
        end
        for (int k = 0; k < 2; k++) begin
            chan_present <= k ? 6'h2D : 6'h3F;
            wreg(8'h0C, 8'h80);
            repeat (600) @(posedge dimming_rate_clk);
            lag(5, c);
            chk(8'(c), 8'((k ? 3 : 5) * (255 / (k ? 4 : 6))));
        end
        chan_present <= 6'h3F;
        wreg(8'h0C, 8'h00);
        wreg(8'h07, 8'h00);
        repeat (40) @(posedge dimming_rate_clk);
        meas(c);
        chk(8'(c), 8'h00);
        wreg(8'h07, 8'hFF);
        $display("internal test done");
        u_host.ext_hi = 3200;
        u_host.ext_lo = 150;
        wreg(8'h01, 8'h01);
        wreg(8'h00, 8'h80);
        repeat (12000) @(posedge dimming_rate_clk);
        e = (256 * 3200) / 3350;
        if (e > 255) e = 255;
        meas(c);
        chk(8'(c), 8'((128 * e) / 255));
        $display("product test done");
        wreg(8'h01, ldp_pkg::MODE_CODE_EXT);
        u_host.tie();
        repeat (600) @(posedge dimming_rate_clk);
        wext(1'b0);
        wext(1'b1);
        repeat (100) @(posedge core_clk);
        chk({2'b0, led_on}, 8'h3F);
        wext(1'b0);
        repeat (100) @(posedge core_clk);
        chk({2'b0, led_on}, 8'h00);
        u_host.ext_hi = 50;
        u_host.ext_lo = 5000;
        wext(1'b1);
        wext(1'b0);
        repeat (4400) @(posedge core_clk);
        chk({7'b0, shutdown}, 8'h01);
        chk({2'b0, led_on}, 8'h00);
        wext(1'b1);
        repeat (20) @(posedge core_clk);
        chk({7'b0, shutdown}, 8'h00);
        chk(8'(u_host.nacks), 8'h00);
        $display("external test done");
        stop_test();
    end
endmodule
